// >>> verilog/cfg_access_pkg.sv
// constants for the configuration-access responder: tokens, register map, field layout, timing
// assumes a token-level link where each symbol is one byte tagged as control or data
package cfg_access_pkg;
   // control tokens
   localparam logic [7:0] TOK_WRITE = 8'hC0;      // 192
   localparam logic [7:0] TOK_READ = 8'hC1;       // 193
   localparam logic [7:0] TOK_PWRITE = 8'h24;     // 36
   localparam logic [7:0] TOK_PREAD = 8'h25;      // 37
   localparam logic [7:0] TOK_END = 8'h01;
   localparam logic [7:0] TOK_ACK = 8'h03;
   localparam logic [7:0] TOK_NACK = 8'h04;
   // register map
   localparam logic [15:0] REG_TILE_CONTROL = 16'h0002;
   localparam logic [31:0] TILE_CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] TILE_CONTROL_WMASK = 32'h03FF_FF36;
   // field positions
   localparam int DELAY_LSB = 18;
   localparam int DIV_LSB = 9;
   localparam int PORT_EN_BIT = 8;
   localparam int DYN_BIT = 5;
   localparam int LP_EN_BIT = 4;
   localparam int UTMI_BIT = 2;
   localparam int ULPI_EN_BIT = 1;
   // peripheral register space held locally
   localparam int PERIPH_DEPTH = 16;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int BOOT_MAX_US = 150;
   localparam int BOOT_CYCLES = BOOT_MAX_US * (CLK_HZ / 1_000_000);
   localparam int RST_MIN_US = 5;
   localparam int RST_CYCLES = (RST_MIN_US * (CLK_HZ / 1_000_000) + 1);
endpackage : cfg_access_pkg

// >>> verilog/tx_clock_divider.sv
// counter-based transmit clock generator driven by the tile clock
// assumes the ratio input is stable between reprograms; a change does not restart the count, which wraps once it reaches or passes the new value
`timescale 1ns/1ns
module tx_clock_divider
   import cfg_access_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_enable,
   input wire logic [8:0] i_ratio,
   // output
   output logic o_tx_clk
);
   logic [8:0] count;

   // count up to the programmed value then wrap
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !i_enable || count >= i_ratio)
         count <= 9'h000;
      else
         count <= count + 9'h001;
   end

   // rise at full value, fall at half value
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !i_enable)
         o_tx_clk <= 1'b0;
      else if (count == i_ratio)
         o_tx_clk <= 1'b1;
      else if (count == (i_ratio >> 1))
         o_tx_clk <= 1'b0;
   end
endmodule : tx_clock_divider

// >>> verilog/config_register_access.sv
// token-framed configuration responder with tile control register and boot sequencing
// assumes a byte-wide token channel with valid/ready on each side; symbols tagged control or data
`timescale 1ns/1ns
module config_register_access
   import cfg_access_pkg::*;
#(
   parameter int BOOT_DELAY = BOOT_CYCLES
)(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // incoming token stream
   input wire logic i_rx_valid,
   input wire logic i_rx_ctrl,
   input wire logic [7:0] i_rx_data,
   output logic o_rx_ready,
   // outgoing token stream
   output logic o_tx_valid,
   output logic o_tx_ctrl,
   output logic [7:0] o_tx_data,
   output logic [23:0] o_tx_dest,
   input wire logic i_tx_ready,
   // thread status for dynamic divide
   input wire logic i_all_paused,
   // tile control and boot outputs
   output logic [7:0] o_tx_data_delay,
   output logic o_tx_clk,
   output logic o_rgmii_port_en,
   output logic o_lp_div_active,
   output logic o_utmi_sel,
   output logic o_ulpi_en,
   output logic o_boot_start
);
   typedef enum {S_IDLE, S_RID, S_REG, S_SIZE, S_DATA, S_END, S_DRAIN,
                 S_RESP, S_RDATA, S_RTAIL} state_t;
   typedef enum {K_WRITE, K_READ, K_PWRITE, K_PREAD} kind_t;

   state_t state;
   kind_t kind;
   logic [31:0] tile_control;
   logic [7:0] periph_mem [PERIPH_DEPTH];
   logic [23:0] reply_id;
   logic [15:0] reg_num;
   logic [31:0] wdata;
   logic [7:0] size;
   logic [2:0] cnt;
   logic [7:0] pcnt;
   logic ok;
   logic [31:0] rdata;
   logic [31:0] boot_count;
   logic div_out;

   // one byte of the current field, most significant first
   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [2:0] i);
      byte_of = w[8'(i) * 8 +: 8];
   endfunction : byte_of

   // periph address stays inside the local array
   function automatic logic in_periph(input logic [8:0] a);
      in_periph = (a < 9'(PERIPH_DEPTH));
   endfunction : in_periph

   wire take = i_rx_valid && o_rx_ready;
   wire send = o_tx_valid && i_tx_ready;

   // parsing is open except from the closing token until the answer is out
   always_ff @(posedge i_clk) begin
      if (i_sys_rst)
         o_rx_ready <= 1'b1;
      else if (take && i_rx_ctrl && i_rx_data == TOK_END && state inside {S_END, S_DRAIN})
         o_rx_ready <= 1'b0;
      else if (state == S_RTAIL && send)
         o_rx_ready <= 1'b1;
   end

   // request parsing and response sequencing
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= S_IDLE;
         kind <= K_WRITE;
         cnt <= 3'h0;
         pcnt <= 8'h00;
         ok <= 1'b0;
         reply_id <= 24'h000000;
         reg_num <= 16'h0000;
         wdata <= 32'h0000_0000;
         size <= 8'h00;
      end else begin
         unique case (state)
            S_IDLE: if (take && i_rx_ctrl) begin
               cnt <= 3'h2;
               ok <= 1'b1;
               if (i_rx_data inside {TOK_WRITE, TOK_READ, TOK_PWRITE, TOK_PREAD})
                  state <= S_RID;
               case (i_rx_data)
                  TOK_WRITE: kind <= K_WRITE;
                  TOK_READ: kind <= K_READ;
                  TOK_PWRITE: kind <= K_PWRITE;
                  TOK_PREAD: kind <= K_PREAD;
                  default: kind <= kind;
               endcase
            end
            S_RID: if (take) begin
               if (i_rx_ctrl) ok <= 1'b0;
               reply_id <= {reply_id[15:0], i_rx_data};
               if (cnt == 3'h0) begin
                  state <= S_REG;
                  cnt <= (kind inside {K_WRITE, K_READ}) ? 3'h1 : 3'h0;
               end else cnt <= cnt - 3'h1;
            end
            S_REG: if (take) begin
               if (i_rx_ctrl) ok <= 1'b0;
               reg_num <= {reg_num[7:0], i_rx_data};
               if (cnt == 3'h0) begin
                  cnt <= 3'h3;
                  unique case (kind)
                     K_WRITE: state <= S_DATA;
                     K_READ: state <= S_END;
                     K_PWRITE, K_PREAD: state <= S_SIZE;
                  endcase
               end else cnt <= cnt - 3'h1;
            end
            S_SIZE: if (take) begin
               if (i_rx_ctrl) ok <= 1'b0;
               size <= i_rx_data;
               pcnt <= 8'h00;
               state <= (kind == K_PWRITE && i_rx_data != 8'h00) ? S_DATA : S_END;
            end
            S_DATA: if (take) begin
               if (i_rx_ctrl) ok <= 1'b0;
               if (kind == K_WRITE) begin
                  wdata <= {wdata[23:0], i_rx_data};
                  if (cnt == 3'h0) state <= S_END;
                  else cnt <= cnt - 3'h1;
               end else begin
                  pcnt <= pcnt + 8'h01;
                  if (pcnt + 8'h01 == size) state <= S_END;
               end
            end
            S_END: if (take) begin
               // a malformed tail turns the answer into a failure and skips to the end token
               if (i_rx_ctrl && i_rx_data == TOK_END) state <= S_RESP;
               else begin
                  ok <= 1'b0;
                  state <= S_DRAIN;
               end
            end
            S_DRAIN: if (take && i_rx_ctrl && i_rx_data == TOK_END) state <= S_RESP;
            S_RESP: if (send) begin
               cnt <= (kind == K_READ) ? 3'h3 : 3'h0;
               pcnt <= 8'h00;
               state <= (ok && (kind inside {K_READ, K_PREAD})) ? S_RDATA : S_RTAIL;
            end
            S_RDATA: if (send) begin
               if (kind == K_READ) begin
                  if (cnt == 3'h0) state <= S_RTAIL;
                  else cnt <= cnt - 3'h1;
               end else begin
                  pcnt <= pcnt + 8'h01;
                  if (pcnt + 8'h01 >= size) state <= S_RTAIL;
               end
            end
            S_RTAIL: if (send) state <= S_IDLE;
         endcase
         // unknown register or out-of-range peripheral access fails
         if (state == S_END && take && i_rx_ctrl && i_rx_data == TOK_END) begin
            if ((kind inside {K_WRITE, K_READ}) && reg_num != REG_TILE_CONTROL) ok <= 1'b0;
            if ((kind inside {K_PWRITE, K_PREAD}) &&
                9'(reg_num[7:0]) + 9'(size) > 9'(PERIPH_DEPTH)) ok <= 1'b0;
         end
      end
   end

   // read data selection; while streaming, the byte after the one now leaving is prepared
   always_comb begin
      rdata = tile_control;
      if (kind == K_PREAD)
         rdata = {24'h000000, periph_mem[4'(reg_num[7:0] + pcnt + 8'(state == S_RDATA))]};
   end

   // response tokens toward the reply channel-end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_tx_valid <= 1'b0;
         o_tx_ctrl <= 1'b0;
         o_tx_data <= 8'h00;
         o_tx_dest <= 24'h000000;
      end else begin
         if (send) o_tx_valid <= 1'b0;
         if (!o_tx_valid || send) begin
            if (state == S_RESP && !send) begin
               o_tx_valid <= 1'b1;
               o_tx_ctrl <= 1'b1;
               o_tx_data <= ok ? TOK_ACK : TOK_NACK;
               o_tx_dest <= reply_id;
            end else if ((state == S_RDATA && send) || (state == S_RESP && send && ok &&
                         (kind inside {K_READ, K_PREAD}))) begin
               o_tx_valid <= 1'b1;
               o_tx_ctrl <= 1'b0;
               // cnt drops as each byte leaves, so streaming sends the byte below it
               o_tx_data <= rdata[7:0];
               if (kind == K_READ)
                  o_tx_data <= byte_of(rdata, (state == S_RESP) ? cnt : cnt - 3'h1);
               if (state == S_RDATA && (kind == K_READ ? cnt == 3'h0 : pcnt + 8'h01 >= size)) begin
                  o_tx_ctrl <= 1'b1;
                  o_tx_data <= TOK_END;
               end
            end else if (state == S_RESP && send) begin
               o_tx_valid <= 1'b1;
               o_tx_ctrl <= 1'b1;
               o_tx_data <= TOK_END;
            end
         end
      end
   end

   // tile control register: only writable fields change, reserved bits stay zero
   always_ff @(posedge i_clk) begin
      if (i_sys_rst)
         tile_control <= TILE_CONTROL_RESET;
      else if (state == S_END && take && i_rx_ctrl && i_rx_data == TOK_END && ok &&
               kind == K_WRITE && reg_num == REG_TILE_CONTROL)
         tile_control <= wdata & TILE_CONTROL_WMASK;
   end

   // peripheral bytes are stored as they stream in; a failed frame may leave a partial write
   always_ff @(posedge i_clk) begin
      if (state == S_DATA && take && kind == K_PWRITE && in_periph(9'(reg_num[7:0]) + 9'(pcnt)))
         periph_mem[4'(reg_num[7:0] + pcnt)] <= i_rx_data;
   end

   // registered control outputs
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_tx_data_delay <= 8'h00;
         o_rgmii_port_en <= 1'b0;
         o_lp_div_active <= 1'b0;
         o_utmi_sel <= 1'b0;
         o_ulpi_en <= 1'b0;
         o_tx_clk <= 1'b0;
      end else begin
         o_tx_data_delay <= tile_control[DELAY_LSB +: 8];
         o_rgmii_port_en <= tile_control[PORT_EN_BIT];
         o_lp_div_active <= tile_control[LP_EN_BIT] &&
                            (!tile_control[DYN_BIT] || i_all_paused);
         o_utmi_sel <= tile_control[UTMI_BIT];
         o_ulpi_en <= tile_control[ULPI_EN_BIT];
         o_tx_clk <= div_out;
      end
   end

   // transmit clock runs only while the RGMII ports are enabled
   tx_clock_divider u_txdiv (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_enable(tile_control[PORT_EN_BIT]),
      .i_ratio(tile_control[DIV_LSB +: 9]),
      .o_tx_clk(div_out)
   );

   // boot starts a fixed delay after reset release, by default the full BOOT_MAX_US limit
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         boot_count <= 32'h0000_0000;
         o_boot_start <= 1'b0;
      end else if (boot_count < 32'(BOOT_DELAY) - 32'h0000_0001) begin
         boot_count <= boot_count + 32'h0000_0001;
      end else begin
         o_boot_start <= 1'b1;
      end
   end
endmodule : config_register_access

// >>> tb/cfg_access_chk.sv
// checker for the configuration responder, bound to its top module
// assumes one clock and the synchronous active-high reset
`timescale 1ns/1ns
module cfg_access_chk
   import cfg_access_pkg::*;
#(
   parameter int BOOT_DELAY = BOOT_CYCLES
)(
   // watched ports
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_rx_valid,
   input wire logic i_rx_ctrl,
   input wire logic [7:0] i_rx_data,
   input wire logic o_rx_ready,
   input wire logic o_tx_valid,
   input wire logic o_tx_ctrl,
   input wire logic [7:0] o_tx_data,
   input wire logic [23:0] o_tx_dest,
   input wire logic i_tx_ready,
   input wire logic o_rgmii_port_en,
   input wire logic o_tx_clk,
   input wire logic o_boot_start
);
   localparam int BOOT_HI = BOOT_DELAY + 2;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic [31:0] since_rst;
   // cycles since reset release, saturating; a counter keeps long boot delays out of ranges
   always_ff @(posedge i_clk) begin
      if (i_sys_rst)
         since_rst <= 32'h0000_0000;
      else if (since_rst < 32'(BOOT_HI))
         since_rst <= since_rst + 32'h0000_0001;
   end
   // frame steps
   sequence end_taken_s;
      i_rx_valid && o_rx_ready && i_rx_ctrl && i_rx_data == TOK_END;
   endsequence
   sequence nack_sent_s;
      o_tx_valid && i_tx_ready && o_tx_ctrl && o_tx_data == TOK_NACK;
   endsequence
   answer_lat_a: assert property (end_taken_s |-> ##2 o_tx_valid && o_tx_ctrl
      && (o_tx_data == TOK_ACK || o_tx_data == TOK_NACK)) else $error("answer late or wrong");
   nack_end_a: assert property (nack_sent_s |-> ##[1:3] (o_tx_valid && o_tx_ctrl
      && o_tx_data == TOK_END)) else $error("fail token not closed");
   tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data)
      && $stable(o_tx_ctrl) && $stable(o_tx_dest)) else $error("response dropped");
   dest_fixed_a: assert property (o_tx_valid && $past(o_tx_valid) |-> $stable(o_tx_dest))
      else $error("dest moved in frame");
   rx_busy_a: assert property (o_tx_valid |-> !o_rx_ready)
      else $error("rx open while answering");
   boot_time_a: assert property (since_rst >= 32'(BOOT_HI) |-> o_boot_start)
      else $error("boot late");
   boot_hold_a: assert property (o_boot_start |=> o_boot_start) else $error("boot dropped");
   clk_off_a: assert property (!o_rgmii_port_en [*3] |-> !o_tx_clk)
      else $error("tx clock runs while off");
endmodule : cfg_access_chk
bind config_register_access cfg_access_chk #(.BOOT_DELAY(BOOT_DELAY)) u_chk (.i_clk(i_clk),
   .i_sys_rst(i_sys_rst), .i_rx_valid(i_rx_valid), .i_rx_ctrl(i_rx_ctrl), .i_rx_data(i_rx_data),
   .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx_ctrl(o_tx_ctrl),
   .o_tx_data(o_tx_data), .o_tx_dest(o_tx_dest), .i_tx_ready(i_tx_ready),
   .o_rgmii_port_en(o_rgmii_port_en), .o_tx_clk(o_tx_clk), .o_boot_start(o_boot_start));

// >>> tb/cfg_requester.sv
// requesting channel-end model: sends token frames, sinks responses
// assumes symbols change at falling edges and are taken on rising edges
`timescale 1ns/1ns
module cfg_requester (
   // clock
   input wire logic i_clk,
   // requests
   output logic o_rx_valid,
   output logic o_rx_ctrl,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready,
   // responses
   input wire logic i_tx_valid,
   input wire logic i_tx_ctrl,
   input wire logic [7:0] i_tx_data,
   input wire logic [23:0] i_tx_dest,
   output logic o_tx_ready,
   // stall select
   input wire logic i_slow
);
   logic [32:0] rsp[$];
   initial begin
      o_rx_valid = 1'b0;
      o_rx_ctrl = 1'b0;
      o_rx_data = 8'hA5;
   end
   // a slow sink stalls every other cycle to exercise holding
   always @(negedge i_clk) o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
   // capture each accepted response symbol with its destination
   always @(posedge i_clk) begin
      if (i_tx_valid && o_tx_ready)
         rsp.push_back({i_tx_dest, i_tx_ctrl, i_tx_data});
   end
   // held until taken; first and last symbols are control tokens
   task frame(input logic [7:0] q[$]);
      for (int i = 0; i < q.size(); i++) begin
         @(negedge i_clk);
         o_rx_valid = 1'b1;
         o_rx_ctrl = (i == 0 || i == q.size() - 1);
         o_rx_data = q[i];
         // ready changes only on rising edges, so the low half shows what the next edge takes
         while (!i_rx_ready) @(negedge i_clk);
         @(posedge i_clk);
      end
      @(negedge i_clk);
      o_rx_valid = 1'b0;
      o_rx_data = ~o_rx_data; // released line shows no stale value
   endtask : frame
endmodule : cfg_requester

// >>> tb/tb_top.sv
// bench for the configuration responder with a requester model on its ports
// assumes a shortened boot delay; bench inputs change at falling edges
`timescale 1ns/1ns
module tb_top;
   import cfg_access_pkg::*;
   logic i_clk, i_sys_rst, i_all_paused, i_slow, rv, rc, rr, tv, tc, tr;
   logic [7:0] rd8, td8, dly;
   logic [23:0] dst;
   logic txc, pen, lpa, utmi, ulpi, boot;
   int num_errors = 0;
   int samples_checked = 0;
   config_register_access #(.BOOT_DELAY(10)) u_config_register_access (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_rx_valid(rv), .i_rx_ctrl(rc), .i_rx_data(rd8), .o_rx_ready(rr),
      .o_tx_valid(tv), .o_tx_ctrl(tc), .o_tx_data(td8), .o_tx_dest(dst), .i_tx_ready(tr),
      .i_all_paused(i_all_paused), .o_tx_data_delay(dly), .o_tx_clk(txc), .o_rgmii_port_en(pen),
      .o_lp_div_active(lpa), .o_utmi_sel(utmi), .o_ulpi_en(ulpi), .o_boot_start(boot));
   cfg_requester u_cfg_requester (.i_clk(i_clk), .o_rx_valid(rv), .o_rx_ctrl(rc),
      .o_rx_data(rd8), .i_rx_ready(rr), .i_tx_valid(tv), .i_tx_ctrl(tc), .i_tx_data(td8),
      .i_tx_dest(dst), .o_tx_ready(tr), .i_slow(i_slow));
   // 20 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task print_verdict;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   // one request frame; a stands for the register number of either space
   task req(input logic [7:0] op, input logic [23:0] id, input logic [15:0] a,
            input logic [7:0] n, input logic [31:0] d);
      logic [7:0] q[$];
      q = {op, id[23:16], id[15:8], id[7:0]};
      if (op == TOK_WRITE || op == TOK_READ) q = {q, a[15:8], a[7:0]};
      else q = {q, a[7:0], n};
      if (op == TOK_WRITE) n = 8'h04;
      if (op == TOK_WRITE || op == TOK_PWRITE)
         for (int i = 0; i < n; i++) q.push_back(d[31-8*i -: 8]);
      q.push_back(TOK_END);
      u_cfg_requester.frame(q);
   endtask : req
   // expected answer: ack, n data bytes msb first, end; or fail, end
   task ans(input logic [23:0] id, input logic ok, input int n, input logic [31:0] d);
      logic [8:0] e[$];
      logic [32:0] r;
      e.delete();
      e.push_back({1'b1, ok ? TOK_ACK : TOK_NACK});
      for (int i = 0; i < n; i++) e.push_back({1'b0, d[31-8*i -: 8]});
      e.push_back({1'b1, TOK_END});
      foreach (e[k]) begin
         for (int w = 0; w < 200 && u_cfg_requester.rsp.size() == 0; w++) @(posedge i_clk);
         r = (u_cfg_requester.rsp.size() > 0) ? u_cfg_requester.rsp.pop_front() : 33'h0;
         chk(r[32:9], id);
         chk(r[8:0], e[k]);
      end
      repeat (3) @(negedge i_clk);
      chk(u_cfg_requester.rsp.size(), 32'h0);
   endtask : ans
   task t_reset_read;
      req(TOK_READ, 24'h123456, REG_TILE_CONTROL, 8'h00, 32'h0);
      ans(24'h123456, 1'b1, 4, TILE_CONTROL_RESET);
      chk({dly, pen, lpa, txc}, 32'h0);
      chk(boot, 32'h1);
   endtask : t_reset_read
   task t_write_mask;
      i_slow = 1'b1;
      req(TOK_WRITE, 24'hABCDEF, REG_TILE_CONTROL, 8'h00, 32'hFFFFFFFF);
      ans(24'hABCDEF, 1'b1, 0, 32'h0);
      req(TOK_READ, 24'h00C30C, REG_TILE_CONTROL, 8'h00, 32'h0);
      ans(24'h00C30C, 1'b1, 4, 32'h03FFFF36);
      chk({dly, pen, utmi, ulpi}, 32'h7FF);
      i_slow = 1'b0;
   endtask : t_write_mask
   task t_bad_reg;
      req(TOK_WRITE, 24'h000001, 16'h0003, 8'h00, 32'h1);
      ans(24'h000001, 1'b0, 0, 32'h0);
      req(TOK_READ, 24'h000002, 16'h0003, 8'h00, 32'h0);
      ans(24'h000002, 1'b0, 0, 32'h0);
   endtask : t_bad_reg
   task t_periph;
      req(TOK_PWRITE, 24'h000702, 16'h0000, 8'h02, 32'hAA550000);
      ans(24'h000702, 1'b1, 0, 32'h0);
      req(TOK_PREAD, 24'h000703, 16'h0000, 8'h02, 32'h0);
      ans(24'h000703, 1'b1, 2, 32'hAA550000);
      req(TOK_PREAD, 24'h000704, 16'h000F, 8'h02, 32'h0);
      ans(24'h000704, 1'b0, 0, 32'h0);
   endtask : t_periph
   task t_lowpower;
      req(TOK_WRITE, 24'h000010, REG_TILE_CONTROL, 8'h00, 32'h30);
      ans(24'h000010, 1'b1, 0, 32'h0);
      chk(lpa, 32'h0);
      i_all_paused = 1'b1;
      repeat (3) @(negedge i_clk);
      chk(lpa, 32'h1);
      i_all_paused = 1'b0;
      req(TOK_WRITE, 24'h000011, REG_TILE_CONTROL, 8'h00, 32'h10);
      ans(24'h000011, 1'b1, 0, 32'h0);
      chk({lpa, utmi, ulpi}, 32'h4);
   endtask : t_lowpower
   task t_txclk;
      int rises;
      int highs;
      logic prev;
      rises = 0;
      highs = 0;
      req(TOK_WRITE, 24'h000012, REG_TILE_CONTROL, 8'h00, 32'h700); // divide by 4
      ans(24'h000012, 1'b1, 0, 32'h0);
      prev = txc;
      // sampled in the low half, where the registered clock output has settled
      for (int c = 0; c < 40; c++) begin
         @(negedge i_clk);
         if (txc === 1'b1 && prev === 1'b0) rises++;
         if (txc === 1'b1) highs++;
         prev = txc;
      end
      chk(rises, 32'hA);
      chk(highs, 32'h14);
   endtask : t_txclk
   // reset, then the scenarios in turn
   initial begin
      i_sys_rst = 1'b1;
      i_all_paused = 1'b0;
      i_slow = 1'b0;
      repeat (6) @(posedge i_clk);
      @(negedge i_clk) i_sys_rst = 1'b0;
      repeat (12) @(negedge i_clk);
      t_reset_read();
      t_write_mask();
      t_bad_reg();
      t_periph();
      t_lowpower();
      t_txclk();
      print_verdict();
   end
   // watchdog far beyond the expected run length
   initial begin
      #(20000 * 50);
      num_errors++;
      print_verdict();
   end
endmodule : tb_top
